// ### design/bcr_top.sv
// bridge command register and the gating it applies to the bridge datapaths
`timescale 1ns/10ps
`default_nettype none
`include "bcr_map.svh"
module bcr_top
	import bcr_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	// configuration access
	input  wire bcr_cfg_t    cfg,
	output logic [31:0]      cfg_rdata,
	output logic             cfg_ack,
	// primary side window hits
	input  wire logic        io_hit,
	input  wire logic        mem_hit,
	input  wire logic        pref_hit,
	output logic             io_claim,
	output logic             mem_claim,
	// upstream traffic from subordinate devices
	input  wire bcr_req_t    up_req,
	output logic             up_forward,
	output logic             up_ur_drop,
	output logic             up_ur_cpl,
	// error reporting
	input  wire logic        own_err_nonfatal,
	input  wire logic        own_err_fatal,
	input  wire logic        devctl_nonfatal_en,
	input  wire logic        devctl_fatal_en,
	input  wire bcr_msg_t    sec_msg,
	output bcr_msg_t         pri_msg,
	// legacy interrupts
	input  wire logic        own_intx,
	input  wire logic        sec_intx,
	output logic             own_intx_out,
	output logic             fwd_intx_out,
	output logic             intx_status
);
	logic [15:0] cmd_r;
	logic        sig_serr_r;
	logic        cmd_we;
	logic        sts_hit;
	logic        io_en;
	logic        mem_en;
	logic        fwd_en;
	logic        serr_en;
	logic        intx_dis;
	logic        send_nf;
	logic        send_f;
	logic        send_cor;
	bcr_msg_t    pri_msg_nxt;

	// command dword decode; status sits in the upper half of the same dword
	function automatic logic dword_hit(input logic [11:0] a);
		return a[11:2] == 10'(`BCR_CMD_OFFSET >> 2);
	endfunction

	assign cmd_we  = cfg.wr & dword_hit(cfg.addr);
	assign sts_hit = cfg.wr & dword_hit(cfg.addr) & cfg.be[3];
	assign io_en    = cmd_r[`BCR_BIT_IO];
	assign mem_en   = cmd_r[`BCR_BIT_MEM];
	assign fwd_en   = cmd_r[`BCR_BIT_FWD];
	assign serr_en  = cmd_r[`BCR_BIT_SERR];
	assign intx_dis = cmd_r[`BCR_BIT_LEGACY_INTERRUPT_DISABLE];

	// writable bits live in the store; read-only bits stay zero
	bcr_cmd_store u_store (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.we      (cmd_we),
		.be      (cfg.be[1:0]),
		.wdata   (cfg.wdata[15:0]),
		.cmd_r   (cmd_r)
	);

	// register read path and one-cycle acknowledge
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_rdata <= 32'h0000_0000;
			cfg_ack   <= 1'b0;
		end else begin
			cfg_ack   <= cfg.wr | cfg.rd;
			cfg_rdata <= (cfg.rd && dword_hit(cfg.addr)) ?
				{1'b0, sig_serr_r, 14'h0000, cmd_r} : 32'h0000_0000;
		end
	end

	// primary window claims
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			io_claim  <= 1'b0;
			mem_claim <= 1'b0;
		end else begin
			io_claim  <= io_hit & io_en;
			mem_claim <= (mem_hit | pref_hit) & mem_en;
		end
	end

	// upstream request gating
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			up_forward <= 1'b0;
			up_ur_drop <= 1'b0;
			up_ur_cpl  <= 1'b0;
		end else begin
			// completions and other requests pass regardless
			up_forward <= up_req.valid & (up_req.is_cpl | ~up_req.is_mem_io | fwd_en);
			up_ur_drop <= up_req.valid & ~up_req.is_cpl & up_req.is_mem_io & ~fwd_en;
			up_ur_cpl  <= up_req.valid & ~up_req.is_cpl & up_req.is_mem_io
				& up_req.non_posted & ~fwd_en;
		end
	end

	// error message selection, fatal first
	always_comb begin
		send_f   = (own_err_fatal & (serr_en | devctl_fatal_en))
			| ((sec_msg == BCR_MSG_FATAL) & serr_en);
		send_nf  = (own_err_nonfatal & (serr_en | devctl_nonfatal_en))
			| ((sec_msg == BCR_MSG_NONFATAL) & serr_en);
		send_cor = sec_msg == BCR_MSG_COR;
		if (send_f) begin
			pri_msg_nxt = BCR_MSG_FATAL;
		end else if (send_nf) begin
			pri_msg_nxt = BCR_MSG_NONFATAL;
		end else if (send_cor) begin
			pri_msg_nxt = BCR_MSG_COR;
		end else begin
			pri_msg_nxt = BCR_MSG_NONE;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pri_msg <= BCR_MSG_NONE;
		end else begin
			pri_msg <= pri_msg_nxt;
		end
	end

	// signalled system error status, set wins over write-one clear
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sig_serr_r <= 1'b0;
		end else if ((send_f | send_nf) & serr_en) begin
			sig_serr_r <= 1'b1;
		end else if (sts_hit & cfg.wdata[16 + `BCR_BIT_SIG_SERR]) begin
			sig_serr_r <= 1'b0;
		end
	end

	// legacy interrupts: own one masked, forwarded one untouched
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			own_intx_out <= 1'b0;
			fwd_intx_out <= 1'b0;
			intx_status  <= 1'b0;
		end else begin
			own_intx_out <= own_intx & ~intx_dis;
			fwd_intx_out <= sec_intx;
			intx_status  <= own_intx;
		end
	end

	// assertions: window claims follow the enables
	io_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		io_claim |-> $past(io_hit) && $past(io_en)) else $error("io claim while disabled");
	mem_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		mem_claim |-> $past(mem_en)) else $error("memory claim while disabled");
	// upstream gating, both with forwarding off and on
	fwd_block_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(up_req.valid && up_req.is_mem_io && !up_req.is_cpl && !fwd_en)
		|=> up_ur_drop && !up_forward) else $error("blocked request forwarded");
	fwd_pass_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(up_req.valid && up_req.is_mem_io && !up_req.is_cpl && fwd_en)
		|=> up_forward && !up_ur_drop && !up_ur_cpl) else $error("enabled request refused");
	ur_cpl_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(up_req.valid && up_req.non_posted && up_req.is_mem_io && !up_req.is_cpl && !fwd_en)
		|=> up_ur_cpl) else $error("no unsupported completion");
	np_only_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		up_ur_cpl |-> $past(up_req.non_posted) && !$past(fwd_en))
		else $error("unsupported completion for posted request");
	cpl_pass_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(up_req.valid && up_req.is_cpl) |=> up_forward && !up_ur_drop)
		else $error("completion blocked");
	other_pass_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(up_req.valid && !up_req.is_mem_io) |=> up_forward && !up_ur_cpl)
		else $error("non memory request blocked");
	// error reporting of own errors and of secondary messages
	own_silent_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(own_err_fatal && !serr_en && !devctl_fatal_en) |=> pri_msg != BCR_MSG_FATAL)
		else $error("own fatal error reported while disabled");
	own_report_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(own_err_nonfatal && serr_en && !own_err_fatal && sec_msg != BCR_MSG_FATAL)
		|=> pri_msg == BCR_MSG_NONFATAL) else $error("own non-fatal error not reported");
	sec_fatal_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(sec_msg == BCR_MSG_FATAL && !serr_en && !own_err_fatal) |=> pri_msg != BCR_MSG_FATAL)
		else $error("fatal forwarded while disabled");
	sec_nf_block_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(sec_msg == BCR_MSG_NONFATAL && !serr_en && !own_err_nonfatal && !own_err_fatal)
		|=> pri_msg == BCR_MSG_NONE) else $error("non-fatal forwarded while disabled");
	sec_fwd_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(sec_msg == BCR_MSG_FATAL && serr_en) |=> pri_msg == BCR_MSG_FATAL)
		else $error("fatal not forwarded");
	cor_pass_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(sec_msg == BCR_MSG_COR) |=> pri_msg != BCR_MSG_NONE) else $error("correctable dropped");
	// legacy interrupts, own masked and forwarded untouched
	intx_mask_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		intx_dis |=> !own_intx_out) else $error("own interrupt not masked");
	intx_pass_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(own_intx && !intx_dis) |=> own_intx_out) else $error("own interrupt lost");
	intx_fwd_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		sec_intx |=> fwd_intx_out) else $error("forwarded interrupt lost");
	intx_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!sec_intx |=> !fwd_intx_out) else $error("forwarded interrupt invented");
	// register bits and the signalled system error status
	ro_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(cmd_r & ~`BCR_CMD_WMASK) == 16'h0000) else $error("read-only bit set");
	serr_set_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		((send_f || send_nf) && serr_en) |=> sig_serr_r) else $error("status not set");
	serr_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(sts_hit && cfg.wdata[16 + `BCR_BIT_SIG_SERR] && !((send_f || send_nf) && serr_en))
		|=> !sig_serr_r) else $error("status not cleared");
	serr_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(sig_serr_r && !sts_hit) |=> sig_serr_r) else $error("status lost without clear");
endmodule
`default_nettype wire

// ### design/bcr_map.svh
// register offsets, field positions and reset values of the bridge command register
`ifndef BCR_MAP_SVH
`define BCR_MAP_SVH
`define BCR_CMD_OFFSET     12'h004
`define BCR_STS_OFFSET     12'h006
`define BCR_CMD_RESET      16'h0000
`define BCR_CMD_WMASK      16'h0547
`define BCR_BIT_IO         0
`define BCR_BIT_MEM        1
`define BCR_BIT_FWD        2
`define BCR_BIT_PARITY     6
`define BCR_BIT_SERR       8
`define BCR_BIT_LEGACY_INTERRUPT_DISABLE      10
`define BCR_BIT_SIG_SERR   14
`endif

// ### design/bcr_pkg.sv
// types shared by the bridge command register block
`default_nettype none
package bcr_pkg;
	// one configuration access
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [11:0] addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} bcr_cfg_t;
	// upstream request classification
	typedef struct packed {
		logic valid;
		logic is_mem_io;
		logic non_posted;
		logic is_cpl;
	} bcr_req_t;
	// error message kinds
	typedef enum logic [1:0] {BCR_MSG_NONE, BCR_MSG_COR, BCR_MSG_NONFATAL, BCR_MSG_FATAL} bcr_msg_t;
endpackage
`default_nettype wire

// ### design/bcr_cmd_store.sv
// storage for the writable command bits with masked byte writes
`timescale 1ns/10ps
`default_nettype none
`include "bcr_map.svh"
module bcr_cmd_store (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	// write side
	input  wire logic        we,
	input  wire logic [1:0]  be,
	input  wire logic [15:0] wdata,
	// stored value
	output logic      [15:0] cmd_r
);
	logic [15:0] lane_mask;
	logic [15:0] cmd_nxt;
	// merge enabled lanes of writable bits only
	always_comb begin
		lane_mask = {{8{be[1]}}, {8{be[0]}}} & `BCR_CMD_WMASK;
		cmd_nxt   = (cmd_r & ~lane_mask) | (wdata & lane_mask);
	end
	// hold the command bits
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cmd_r <= `BCR_CMD_RESET;
		end else if (we) begin
			cmd_r <= cmd_nxt;
		end
	end
endmodule
`default_nettype wire

// ### testbench/bcr_rc_model.sv
// configuration requester model standing in for the upstream root port
`timescale 1ns/10ps
`default_nettype none
module bcr_rc_model
	import bcr_pkg::*;
(
	// clock
	input  wire logic        ref_clk,
	// configuration access
	output bcr_cfg_t         cfg,
	input  wire logic        cfg_ack,
	input  wire logic [31:0] cfg_rdata
);
	initial cfg = '0;

	// one access: a single-cycle strobe, then a bounded wait for the acknowledge
	task automatic access(input logic w, input logic [11:0] a, input logic [3:0] be,
		input logic [31:0] d, output logic [31:0] q, output logic ok);
		int n;
		@(posedge ref_clk);
		cfg <= '{wr: w, rd: !w, addr: a, be: be, wdata: d};
		@(posedge ref_clk);
		// released data lines must not keep showing the last value
		cfg <= '{wr: 1'h0, rd: 1'h0, addr: ~a, be: 4'h0, wdata: ~d};
		ok = 1'h0;
		n = 0;
		while (!ok && n < 8) begin
			#1;
			ok = (cfg_ack === 1'h1);
			q = cfg_rdata;
			if (!ok)
				@(posedge ref_clk);
			n++;
		end
	endtask
endmodule
`default_nettype wire

// ### testbench/bridge_command_register_tb.sv
// self-checking testbench for the bridge command register block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
	$display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module bridge_command_register_tb;
	import bcr_pkg::*;
	logic        ref_clk = 1'h0;
	logic        rst_b = 1'h0;
	bcr_cfg_t    cfg;
	logic [31:0] cfg_rdata;
	logic        cfg_ack, io_claim, mem_claim, up_forward, up_ur_drop, up_ur_cpl;
	logic        io_hit = 1'h0, mem_hit = 1'h0, pref_hit = 1'h0;
	bcr_req_t    up_req = '0;
	logic        own_err_nonfatal = 1'h0, own_err_fatal = 1'h0;
	logic        devctl_nonfatal_en = 1'h0, devctl_fatal_en = 1'h0;
	bcr_msg_t    sec_msg = BCR_MSG_NONE;
	bcr_msg_t    pri_msg;
	logic        own_intx = 1'h0, sec_intx = 1'h0;
	logic        own_intx_out, fwd_intx_out, intx_status;
	int          errors = 0;
	int          check_count = 0;

	// 10 MHz reference clock
	always #50 ref_clk = ~ref_clk;

	bcr_top u_dut (.ref_clk, .rst_b, .cfg, .cfg_rdata, .cfg_ack, .io_hit, .mem_hit,
		.pref_hit, .io_claim, .mem_claim, .up_req, .up_forward, .up_ur_drop, .up_ur_cpl,
		.own_err_nonfatal, .own_err_fatal, .devctl_nonfatal_en, .devctl_fatal_en,
		.sec_msg, .pri_msg, .own_intx, .sec_intx, .own_intx_out, .fwd_intx_out,
		.intx_status);
	bcr_rc_model u_rc (.ref_clk, .cfg, .cfg_ack, .cfg_rdata);

	// verdict and end of run
	task final_report;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// configuration access; a read compares against the expected dword
	task acc(input logic w, input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
		logic [31:0] q;
		logic        ok;
		u_rc.access(w, a, be, d, q, ok);
		if (!ok) begin
			errors++;
			final_report();
		end
		if (!w)
			`CHK(q, d)
	endtask

	// let one registered stage pass, then sample settled outputs
	task go;
		@(posedge ref_clk);
		#1;
	endtask

	task req(input bcr_req_t r, input logic [2:0] e);
		@(posedge ref_clk);
		up_req <= r;
		go();
		`CHK({up_forward, up_ur_drop, up_ur_cpl}, e)
	endtask

	task msg(input bcr_msg_t m, input bcr_msg_t e);
		@(posedge ref_clk);
		sec_msg <= m;
		go();
		`CHK(pri_msg, e)
	endtask

	initial begin
		repeat (12) @(posedge ref_clk);
		rst_b <= 1'h1;
		acc(1'h0, 12'h004, 4'hf, 32'h0);
		acc(1'h1, 12'h004, 4'h3, 32'hffff_ffff);
		acc(1'h0, 12'h004, 4'hf, 32'h0000_0547);
		acc(1'h0, 12'h008, 4'hf, 32'h0);
		acc(1'h1, 12'h004, 4'h3, 32'h0);
		// primary window hits with decoding off, then on
		@(posedge ref_clk);
		io_hit <= 1'h1;
		mem_hit <= 1'h1;
		go();
		`CHK({io_claim, mem_claim}, 2'h0)
		acc(1'h1, 12'h004, 4'h3, 32'h3);
		go();
		`CHK({io_claim, mem_claim}, 2'h3)
		@(posedge ref_clk);
		mem_hit <= 1'h0;
		pref_hit <= 1'h1;
		go();
		`CHK(mem_claim, 1'h1)
		// upstream requests with forwarding off, then on
		for (int i = 0; i < 2; i++) begin
			acc(1'h1, 12'h004, 4'h3, i ? 32'h4 : 32'h0);
			req('0, 3'h0);
			req('{1'h1, 1'h1, 1'h0, 1'h0}, i ? 3'h4 : 3'h2);
			req('{1'h1, 1'h1, 1'h1, 1'h0}, i ? 3'h4 : 3'h3);
			req('{1'h1, 1'h0, 1'h0, 1'h1}, 3'h4);
			req('{1'h1, 1'h0, 1'h1, 1'h0}, 3'h4);
		end
		req('0, 3'h0);
		// error messages with system error reporting off
		acc(1'h1, 12'h004, 4'h3, 32'h0);
		msg(BCR_MSG_FATAL, BCR_MSG_NONE);
		msg(BCR_MSG_NONFATAL, BCR_MSG_NONE);
		msg(BCR_MSG_COR, BCR_MSG_COR);
		msg(BCR_MSG_NONE, BCR_MSG_NONE);
		@(posedge ref_clk);
		own_err_fatal <= 1'h1;
		go();
		`CHK(pri_msg, BCR_MSG_NONE)
		@(posedge ref_clk);
		devctl_fatal_en <= 1'h1;
		go();
		`CHK(pri_msg, BCR_MSG_FATAL)
		@(posedge ref_clk);
		own_err_fatal <= 1'h0;
		devctl_fatal_en <= 1'h0;
		own_err_nonfatal <= 1'h1;
		go();
		`CHK(pri_msg, BCR_MSG_NONE)
		@(posedge ref_clk);
		devctl_nonfatal_en <= 1'h1;
		go();
		`CHK(pri_msg, BCR_MSG_NONFATAL)
		@(posedge ref_clk);
		own_err_nonfatal <= 1'h0;
		devctl_nonfatal_en <= 1'h0;
		go();
		acc(1'h0, 12'h004, 4'hf, 32'h0);
		// system error reporting on
		acc(1'h1, 12'h004, 4'h3, 32'h100);
		msg(BCR_MSG_FATAL, BCR_MSG_FATAL);
		msg(BCR_MSG_NONFATAL, BCR_MSG_NONFATAL);
		msg(BCR_MSG_COR, BCR_MSG_COR);
		msg(BCR_MSG_NONE, BCR_MSG_NONE);
		acc(1'h0, 12'h004, 4'hf, 32'h4000_0100);
		// own error reported with system error on; a clear loses to a new set
		@(posedge ref_clk);
		own_err_nonfatal <= 1'h1;
		go();
		`CHK(pri_msg, BCR_MSG_NONFATAL)
		msg(BCR_MSG_FATAL, BCR_MSG_FATAL);
		acc(1'h1, 12'h004, 4'hc, 32'h4000_0000);
		acc(1'h0, 12'h004, 4'hf, 32'h4000_0100);
		@(posedge ref_clk);
		own_err_nonfatal <= 1'h0;
		sec_msg <= BCR_MSG_NONE;
		go();
		`CHK(pri_msg, BCR_MSG_NONE)
		acc(1'h1, 12'h004, 4'hc, 32'h4000_0000);
		acc(1'h0, 12'h004, 4'hf, 32'h0000_0100);
		// legacy interrupts, own masked and forwarded untouched
		@(posedge ref_clk);
		own_intx <= 1'h1;
		sec_intx <= 1'h1;
		go();
		`CHK({own_intx_out, fwd_intx_out}, 2'h3)
		acc(1'h1, 12'h004, 4'h3, 32'h400);
		go();
		`CHK({own_intx_out, fwd_intx_out, intx_status}, 3'h3)
		// reset in mid-run clears every output and the command bits
		@(posedge ref_clk);
		own_intx <= 1'h0;
		sec_intx <= 1'h0;
		@(posedge ref_clk);
		rst_b <= 1'h0;
		go();
		`CHK({io_claim, mem_claim, up_forward, up_ur_drop, up_ur_cpl, own_intx_out}, 6'h0)
		`CHK({pri_msg, cfg_ack, fwd_intx_out, intx_status}, 5'h0)
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'h1;
		acc(1'h0, 12'h004, 4'hf, 32'h0);
		final_report();
	end
endmodule
`default_nettype wire
